// ### hw/asr_device.sv
// Converter end: power-on reset, sampling and conversion control, serial
// result readout and the nap and sleep sequencer.
// Assumes every link pin and the supply monitor are asynchronous to mclk.
//
// Operation
// - Reset and reinitialize whenever supply is low.
// - Host waits after power-on reset before converting; its settle timer restarts only on host reset and wake.
// - Strobe rise samples, strobe fall converts and reads; the device holds the input at the strobe fall.
// - Conversion and readout paced by serial clock.
// - Host strobe high width near thirty nanoseconds; the host holds it high for one 50 ns mclk cycle.
// - Serial clock falls shift result out, MSB first.
// - Host clock fast enough for full rate.
// - Host requests nap: two strobes, clock static.
// - Second strobe rise with idle clock naps.
// - Nap ends on serial clock rise.
// - Two more strobes in nap enter sleep.
// - CMOS: serial clock rise leaves sleep.
// - Host waits for reference after leaving sleep.
// - LVDS: fifth strobe leaves sleep.
// - Clock activity blocks nap and sleep entry.
// - Fifth strobe also leaves sleep in CMOS.
// - Strobes alone cycle operational, nap, sleep forever.
// - Select pin chooses CMOS or LVDS signalling.
// - CMOS uses positive pins; negatives pulled down.
// - LVDS uses differential data and clock pairs.
// - Readout returns previous conversion result.
`timescale 1ns/1ps
`include "asr_map.svh"

module asr_device (
    input  wire logic        mclk,
    input  wire logic        nrst,
    asr_if.dev               link,
    input  wire logic        supply_good,
    input  wire logic [15:0] analog_code,
    output logic             por_active,
    output logic [2:0]       power_state,
    output logic [15:0]      last_result
);

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [`ASR_IN_LANES-1:0] async_in;
    logic [`ASR_IN_LANES-1:0] sync1_r;
    logic [`ASR_IN_LANES-1:0] sync2_r;

    assign async_in[`ASR_IN_STB]    = link.convert_strobe_n;
    assign async_in[`ASR_IN_SCKP]   = link.sclk_pos;
    assign async_in[`ASR_IN_SCKN]   = link.sclk_neg;
    assign async_in[`ASR_IN_LVDS]   = link.lvds_sel;
    assign async_in[`ASR_IN_SUPPLY] = supply_good;

    genvar gi;
    generate
        for (gi = 0; gi < `ASR_IN_LANES; gi = gi + 1) begin : g_sync
            always_ff @(posedge mclk) begin
                if (!nrst) begin
                    sync1_r[gi] <= 1'b0;
                    sync2_r[gi] <= 1'b0;
                end else begin
                    sync1_r[gi] <= async_in[gi];
                    sync2_r[gi] <= sync1_r[gi];
                end
            end
        end
    endgenerate

    logic stb_s;
    logic lvds_s;
    logic supply_s;

    assign stb_s    = sync2_r[`ASR_IN_STB];
    assign lvds_s   = sync2_r[`ASR_IN_LVDS];
    assign supply_s = sync2_r[`ASR_IN_SUPPLY];

    // ----------------------------------------------------------------
    // Power-on reset
    // ----------------------------------------------------------------
    // Every piece of state below restarts while the supply is low, so
    // a brown-out leaves no half-finished frame or power sequence.
    logic rst_int;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            por_active <= 1'b1;
        end else begin
            por_active <= ~supply_s;
        end
    end

    assign rst_int = ~nrst | por_active;

    // ----------------------------------------------------------------
    // Serial clock receiver
    // ----------------------------------------------------------------
    // In LVDS a level is only taken when the pair is complementary; an
    // equal pair holds the last level instead of inventing an edge.
    logic sck_lvl_r;
    logic sck_prev_r;
    logic stb_prev_r;
    logic sck_rise;
    logic sck_fall;
    logic stb_rise;
    logic stb_fall;

    always_ff @(posedge mclk) begin
        if (rst_int) begin
            sck_lvl_r <= 1'b0;
        end else if (!lvds_s) begin
            sck_lvl_r <= sync2_r[`ASR_IN_SCKP];
        end else if (sync2_r[`ASR_IN_SCKP] != sync2_r[`ASR_IN_SCKN]) begin
            sck_lvl_r <= sync2_r[`ASR_IN_SCKP];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst_int) begin
            sck_prev_r <= 1'b0;
            stb_prev_r <= 1'b0;
        end else begin
            sck_prev_r <= sck_lvl_r;
            stb_prev_r <= stb_s;
        end
    end

    assign sck_rise = sck_lvl_r & ~sck_prev_r;
    assign sck_fall = ~sck_lvl_r & sck_prev_r;
    assign stb_rise = stb_s & ~stb_prev_r;
    assign stb_fall = ~stb_s & stb_prev_r;

    // ----------------------------------------------------------------
    // Nap and sleep sequencer
    // ----------------------------------------------------------------
    // The pulse count only grows while the serial clock stays idle; any
    // clock rise, except one in LVDS sleep, starts the count again from zero.
    asr_pkg::asr_pwr_e pwr_r;
    logic [2:0]        pulse_cnt_r;

    always_ff @(posedge mclk) begin
        if (rst_int) begin
            pwr_r       <= asr_pkg::ASR_PWR_OPER;
            pulse_cnt_r <= 3'h0;
        end else if (sck_rise) begin
            if (pwr_r != asr_pkg::ASR_PWR_SLEEP || !lvds_s) begin
                pulse_cnt_r <= 3'h0;
            end
            if (pwr_r == asr_pkg::ASR_PWR_NAP) begin
                pwr_r <= asr_pkg::ASR_PWR_OPER;
            end else if (pwr_r == asr_pkg::ASR_PWR_SLEEP && !lvds_s) begin
                pwr_r <= asr_pkg::ASR_PWR_OPER;
            end
        end else if (stb_rise) begin
            pulse_cnt_r <= pulse_cnt_r + 3'h1;
            unique case (pwr_r)
                asr_pkg::ASR_PWR_OPER: begin
                    if (pulse_cnt_r + 3'h1 == `ASR_NAP_PULSES) begin
                        pwr_r <= asr_pkg::ASR_PWR_NAP;
                    end
                end
                asr_pkg::ASR_PWR_NAP: begin
                    if (pulse_cnt_r + 3'h1 == `ASR_SLEEP_PULSES) begin
                        pwr_r <= asr_pkg::ASR_PWR_SLEEP;
                    end
                end
                asr_pkg::ASR_PWR_SLEEP: begin
                    if (pulse_cnt_r + 3'h1 == `ASR_WAKE_PULSES) begin
                        pwr_r       <= asr_pkg::ASR_PWR_OPER;
                        pulse_cnt_r <= 3'h0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst_int) begin
            power_state <= asr_pkg::ASR_PWR_OPER;
        end else begin
            power_state <= pwr_r;
        end
    end

    // ----------------------------------------------------------------
    // Conversion and readout
    // ----------------------------------------------------------------
    // The input is held when the strobe falls, but the word shifted out
    // in that frame is the one held at the strobe fall before; the very
    // first frame after reset therefore carries no real sample, and the first after sleep a stale one.
    logic [15:0] result_r;
    logic [15:0] shift_r;
    logic [4:0]  bits_left_r;

    always_ff @(posedge mclk) begin
        if (rst_int) begin
            result_r    <= 16'h0000;
            shift_r     <= 16'h0000;
            bits_left_r <= 5'h00;
        end else if (stb_fall && pwr_r == asr_pkg::ASR_PWR_OPER) begin
            shift_r     <= result_r;
            result_r    <= analog_code;
            bits_left_r <= `ASR_FRAME_BITS;
        end else if (sck_fall && bits_left_r != 5'h00) begin
            shift_r     <= {shift_r[14:0], 1'b0};
            bits_left_r <= bits_left_r - 5'h01;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst_int) begin
            last_result <= 16'h0000;
        end else begin
            last_result <= result_r;
        end
    end

    // ----------------------------------------------------------------
    // Serial data driver
    // ----------------------------------------------------------------
    logic data_bit;

    assign data_bit = (bits_left_r != 5'h00) ? shift_r[15] : 1'b0;

    always_ff @(posedge mclk) begin
        if (rst_int) begin
            link.serial_out_pos <= 1'b0;
            link.serial_out_neg <= 1'b0;
        end else begin
            link.serial_out_pos <= data_bit;
            // Only the LVDS pair carries a complement; in CMOS the pin
            // sits at its pulled-down level.
            link.serial_out_neg <= lvds_s ? ~data_bit : 1'b0;
        end
    end

endmodule

// ### hw/asr_host.sv
// Host end: Wishbone register slave that sequences strobes and serial
// clock to convert, read back, nap, sleep and wake the converter.
// Assumes a classic Wishbone master on mclk and the converter on the link.
//
// The implementer's own choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
`include "asr_map.svh"

module asr_host #(
    parameter int SETTLE_CYCLES = `ASR_SETTLE_US * `ASR_MCLK_MHZ
) (
    input  wire logic        mclk,
    input  wire logic        nrst,
    asr_if.host              link,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o
);

    localparam int STB_HI_CYC = (`ASR_STB_HIGH_NS + `ASR_MCLK_NS - 1) / `ASR_MCLK_NS;

    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    logic        acc;
    logic        wr_lo;
    logic        busy;
    logic        ready_r;
    logic        valid_r;
    logic        done_ok;
    logic [15:0] data_r;
    logic [2:0]  cmd;
    logic        take;

    assign acc   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_lo = acc & wb_we_i & wb_sel_i[0];
    assign cmd   = wb_dat_i[2:0];

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= acc;
            wb_dat_o <= 32'h0000_0000;
            if (acc && !wb_we_i) begin
                unique case (wb_adr_i)
                    `ASR_REG_CTRL: wb_dat_o[`ASR_CTRL_LVDS] <= link.lvds_sel;
                    `ASR_REG_STAT: wb_dat_o[`ASR_STAT_VALID:`ASR_STAT_BUSY] <=
                        {valid_r, ready_r, busy};
                    `ASR_REG_DATA: wb_dat_o[15:0] <= data_r;
                    default:       wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            link.lvds_sel <= 1'b0;
        end else if (wr_lo && wb_adr_i == `ASR_REG_CTRL) begin
            link.lvds_sel <= wb_dat_i[`ASR_CTRL_LVDS];
        end
    end

    // A new result arriving in the cycle its flag is read still sets it.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            valid_r <= 1'b0;
        end else if (done_ok) begin
            valid_r <= 1'b1;
        end else if (acc && !wb_we_i && wb_adr_i == `ASR_REG_DATA) begin
            valid_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Link sequencer
    // ----------------------------------------------------------------
    asr_pkg::asr_hst_e st_r;
    logic [7:0]  tmr_r;
    logic [2:0]  pulses_r;
    logic [4:0]  bits_r;
    logic        capture_r;
    logic        wake_r;
    logic        primed_r;
    logic [15:0] shift_r;
    logic [17:0] settle_r;
    logic [1:0]  dout_s1_r;
    logic [1:0]  dout_s2_r;
    logic        rx_bit;

    assign busy = (st_r != asr_pkg::ASR_HST_IDLE);
    // Conversions are refused until the reference has settled.
    assign take = wr_lo && wb_adr_i == `ASR_REG_CMD && !busy &&
                  (cmd != `ASR_CMD_CONVERT || ready_r);
    assign rx_bit = link.lvds_sel ? (dout_s2_r[0] & ~dout_s2_r[1]) : dout_s2_r[0];

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            dout_s1_r <= 2'h0;
            dout_s2_r <= 2'h0;
        end else begin
            dout_s1_r <= {link.serial_out_neg, link.serial_out_pos};
            dout_s2_r <= dout_s1_r;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            st_r                  <= asr_pkg::ASR_HST_IDLE;
            tmr_r                 <= 8'h00;
            pulses_r              <= 3'h0;
            bits_r                <= 5'h00;
            capture_r             <= 1'b0;
            wake_r                <= 1'b0;
            link.convert_strobe_n <= 1'b0;
            link.sclk_pos         <= 1'b0;
            link.sclk_neg_drv     <= 1'b1;
            shift_r               <= 16'h0000;
        end else begin
            unique case (st_r)
                asr_pkg::ASR_HST_IDLE: begin
                    if (take) begin
                        capture_r <= (cmd == `ASR_CMD_CONVERT);
                        wake_r    <= (cmd == `ASR_CMD_WAKE_SCK) || (cmd == `ASR_CMD_WAKE_STB);
                        pulses_r  <= (cmd == `ASR_CMD_NAP)   ? `ASR_NAP_PULSES :
                                     (cmd == `ASR_CMD_SLEEP) ? `ASR_SLEEP_PULSES :
                                     (cmd == `ASR_CMD_WAKE_SCK) ? 3'h0 : 3'h1;
                        bits_r    <= (cmd == `ASR_CMD_CONVERT) ? `ASR_FRAME_BITS :
                                     (cmd == `ASR_CMD_WAKE_SCK) ? 5'h01 : 5'h00;
                        tmr_r     <= 8'h00;
                        st_r      <= (cmd == `ASR_CMD_WAKE_SCK) ? asr_pkg::ASR_HST_SCK_HI
                                                                : asr_pkg::ASR_HST_PULSE;
                        if (cmd == `ASR_CMD_WAKE_SCK) begin
                            link.sclk_pos <= 1'b1;
                            link.sclk_neg_drv <= 1'b0;
                        end else begin
                            link.convert_strobe_n <= 1'b1;
                        end
                    end
                end
                asr_pkg::ASR_HST_PULSE: begin
                    tmr_r <= tmr_r + 8'h01;
                    if (tmr_r + 8'h01 >= 8'(STB_HI_CYC)) begin
                        link.convert_strobe_n <= 1'b0;
                        tmr_r    <= 8'h00;
                        pulses_r <= pulses_r - 3'h1;
                        st_r     <= asr_pkg::ASR_HST_GAP;
                    end
                end
                asr_pkg::ASR_HST_GAP: begin
                    tmr_r <= tmr_r + 8'h01;
                    if (tmr_r + 8'h01 >= `ASR_STB_GAP_CYC) begin
                        tmr_r <= 8'h00;
                        if (pulses_r != 3'h0) begin
                            link.convert_strobe_n <= 1'b1;
                            st_r <= asr_pkg::ASR_HST_PULSE;
                        end else if (bits_r != 5'h00) begin
                            link.sclk_pos <= 1'b1;
                            link.sclk_neg_drv <= 1'b0;
                            st_r <= asr_pkg::ASR_HST_SCK_HI;
                        end else begin
                            st_r <= asr_pkg::ASR_HST_IDLE;
                        end
                    end
                end
                asr_pkg::ASR_HST_SCK_HI: begin
                    tmr_r <= tmr_r + 8'h01;
                    if (tmr_r + 8'h01 >= `ASR_SCK_HALF_CYC) begin
                        shift_r       <= {shift_r[14:0], rx_bit};
                        link.sclk_pos <= 1'b0;
                        link.sclk_neg_drv <= 1'b1;
                        tmr_r         <= 8'h00;
                        bits_r        <= bits_r - 5'h01;
                        st_r          <= asr_pkg::ASR_HST_SCK_LO;
                    end
                end
                asr_pkg::ASR_HST_SCK_LO: begin
                    tmr_r <= tmr_r + 8'h01;
                    if (tmr_r + 8'h01 >= `ASR_SCK_HALF_CYC) begin
                        tmr_r <= 8'h00;
                        if (bits_r != 5'h00) begin
                            link.sclk_pos <= 1'b1;
                            link.sclk_neg_drv <= 1'b0;
                            st_r <= asr_pkg::ASR_HST_SCK_HI;
                        end else begin
                            st_r <= asr_pkg::ASR_HST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // The negative clock pin is left undriven in CMOS.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            link.sclk_neg_oe  <= 1'b0;
        end else begin
            link.sclk_neg_oe  <= link.lvds_sel;
        end
    end

    // ----------------------------------------------------------------
    // Settling and result bookkeeping
    // ----------------------------------------------------------------
    logic fin;

    assign fin     = (st_r == asr_pkg::ASR_HST_SCK_LO || st_r == asr_pkg::ASR_HST_GAP) &&
                     tmr_r + 8'h01 >= `ASR_SCK_HALF_CYC && bits_r == 5'h00 && pulses_r == 3'h0;
    assign done_ok = fin && capture_r && primed_r && st_r == asr_pkg::ASR_HST_SCK_LO;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            settle_r <= 18'h00000;
            ready_r  <= 1'b0;
        end else if (fin && wake_r) begin
            settle_r <= 18'h00000;
            ready_r  <= 1'b0;
        end else if (settle_r + 18'h00001 >= 18'(SETTLE_CYCLES)) begin
            ready_r  <= 1'b1;
        end else begin
            settle_r <= settle_r + 18'h00001;
        end
    end

    // The first frame after reset or a power command holds a stale word.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            primed_r <= 1'b0;
            data_r   <= 16'h0000;
        end else if (take && cmd != `ASR_CMD_CONVERT) begin
            primed_r <= 1'b0;
        end else if (fin && capture_r && st_r == asr_pkg::ASR_HST_SCK_LO) begin
            primed_r <= 1'b1;
            if (primed_r) begin
                data_r <= shift_r;
            end
        end
    end

endmodule

// ### include/asr_if.sv
// Pins between the converter and its host.
// Assumes the bench joins both ends through one instance of this interface.
`timescale 1ns/1ps
interface asr_if;
    logic convert_strobe_n;
    logic sclk_pos;
    logic sclk_neg_drv;
    logic sclk_neg_oe;
    logic sclk_neg;
    logic serial_out_pos;
    logic serial_out_neg;
    logic lvds_sel;

    // The device pulls the undriven negative clock pin down.
    assign sclk_neg = sclk_neg_oe ? sclk_neg_drv : 1'b0;

    modport dev (
        input  convert_strobe_n,
        input  sclk_pos,
        input  sclk_neg,
        input  lvds_sel,
        output serial_out_pos,
        output serial_out_neg
    );

    modport host (
        output convert_strobe_n,
        output sclk_pos,
        output sclk_neg_drv,
        output sclk_neg_oe,
        output lvds_sel,
        input  serial_out_pos,
        input  serial_out_neg
    );
endinterface

// ### include/asr_map.svh
// Register offsets, field positions and timing figures of the converter readout link.
// Assumes inclusion by bare name from the design files.
`ifndef ASR_MAP_SVH
`define ASR_MAP_SVH

// ----------------------------------------------------------------
// Timing figures and clock rate
// ----------------------------------------------------------------
`define ASR_MCLK_NS        50
`define ASR_MCLK_MHZ       20
`define ASR_STB_HIGH_NS    30
`define ASR_SETTLE_US      10000
`define ASR_SCK_HALF_CYC   8'h08
`define ASR_STB_GAP_CYC    8'h08

// ----------------------------------------------------------------
// Frame and power sequence counts
// ----------------------------------------------------------------
`define ASR_FRAME_BITS     5'h10
`define ASR_NAP_PULSES     3'h2
`define ASR_SLEEP_PULSES   3'h4
`define ASR_WAKE_PULSES    3'h5

// ----------------------------------------------------------------
// Synchroniser lanes of the device end
// ----------------------------------------------------------------
`define ASR_IN_STB         0
`define ASR_IN_SCKP        1
`define ASR_IN_SCKN        2
`define ASR_IN_LVDS        3
`define ASR_IN_SUPPLY      4
`define ASR_IN_LANES       5

// ----------------------------------------------------------------
// Host registers and fields
// ----------------------------------------------------------------
`define ASR_REG_CMD        8'h00
`define ASR_REG_CTRL       8'h04
`define ASR_REG_STAT       8'h08
`define ASR_REG_DATA       8'h0C
`define ASR_CMD_CONVERT    3'h1
`define ASR_CMD_NAP        3'h2
`define ASR_CMD_SLEEP      3'h3
`define ASR_CMD_WAKE_SCK   3'h4
`define ASR_CMD_WAKE_STB   3'h5
`define ASR_CTRL_LVDS      0
`define ASR_STAT_BUSY      0
`define ASR_STAT_READY     1
`define ASR_STAT_VALID     2

`endif

// ### include/asr_pkg.sv
// Types shared by both ends of the converter readout link.
// Assumes asr_map.svh is on the include path.
package asr_pkg;

    // ----------------------------------------------------------------
    // Power states of the device end
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ASR_PWR_OPER  = 3'h1,
        ASR_PWR_NAP   = 3'h2,
        ASR_PWR_SLEEP = 3'h4
    } asr_pwr_e;

    // ----------------------------------------------------------------
    // Sequencer states of the host end
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        ASR_HST_IDLE   = 5'h01,
        ASR_HST_PULSE  = 5'h02,
        ASR_HST_GAP    = 5'h04,
        ASR_HST_SCK_HI = 5'h08,
        ASR_HST_SCK_LO = 5'h10
    } asr_hst_e;

endpackage

// ### verif/asr_monitor.sv
// Pin checker for the converter link.
// Assumes the bench instantiates it beside the link interface.
`timescale 1ns/1ps
module asr_monitor (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic convert_strobe_n,
    input wire logic sclk_pos,
    input wire logic sclk_neg_oe,
    input wire logic sclk_neg,
    input wire logic serial_out_pos,
    input wire logic serial_out_neg,
    input wire logic lvds_sel
);
    logic [4:0] rises_r;
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    // Clock rises since the last strobe fall; a wake pulse leaves one.
    always_ff @(posedge mclk) begin
        if (!nrst || $fell(convert_strobe_n)) begin
            rises_r <= 5'h00;
        end else if ($rose(sclk_pos)) begin
            rises_r <= rises_r + 5'h01;
        end
    end
    a_strobe_one_cycle: assert property ($rose(convert_strobe_n) |=> $fell(convert_strobe_n))
        else $error("strobe high longer than one cycle");
    a_gap_after_fall: assert property ($fell(convert_strobe_n) |-> !sclk_pos [*8])
        else $error("clock moved inside strobe gap");
    a_sck_high_half: assert property ($rose(sclk_pos) |-> sclk_pos [*8] ##1 !sclk_pos)
        else $error("clock high phase not eight cycles");
    a_frame_bit_count: assert property ($rose(convert_strobe_n) |-> rises_r inside {0, 1, 16})
        else $error("frame clock count wrong");
    a_cmos_data_neg: assert property (!lvds_sel [*8] |-> !serial_out_neg)
        else $error("negative data pin driven in single-ended mode");
    a_lvds_data_pair: assert property (lvds_sel [*8] |-> serial_out_neg != serial_out_pos)
        else $error("data pair not complementary");
    a_cmos_clk_neg: assert property (!lvds_sel [*2] |-> !sclk_neg_oe && !sclk_neg)
        else $error("negative clock pin driven in single-ended mode");
    a_lvds_clk_pair: assert property (lvds_sel [*2] |-> sclk_neg_oe && sclk_neg == !sclk_pos)
        else $error("clock pair not complementary");
endmodule

// ### verif/asr_tb_top.sv
// Bench joining the host and converter ends over one link.
// Assumes asr_map.svh on the include path and the design compiled first.
`timescale 1ns/1ps
module asr_tb_top;
    logic        mclk = 1'b0;
    logic        nrst = 1'b0;
    logic        supply_good = 1'b1;
    logic [15:0] analog_code = 16'h0000;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] q;
    logic        ack;
    logic        por_active;
    logic [2:0]  power_state;
    logic [15:0] last_result;
    int          num_errors = 0;
    int          total_checks = 0;
    int          cycles = 0;
    asr_if u_asr_if ();
    // A short settle keeps the run small; every command wait below polls ready.
    asr_host #(.SETTLE_CYCLES(50)) u_asr_host (.mclk(mclk), .nrst(nrst), .link(u_asr_if),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_sel_i(4'hF), .wb_dat_o(rdat), .wb_ack_o(ack));
    asr_device u_asr_device (.mclk(mclk), .nrst(nrst), .link(u_asr_if),
        .supply_good(supply_good), .analog_code(analog_code), .por_active(por_active),
        .power_state(power_state), .last_result(last_result));
    asr_monitor u_asr_monitor (.mclk(mclk), .nrst(nrst),
        .convert_strobe_n(u_asr_if.convert_strobe_n), .sclk_pos(u_asr_if.sclk_pos),
        .sclk_neg_oe(u_asr_if.sclk_neg_oe), .sclk_neg(u_asr_if.sclk_neg),
        .serial_out_pos(u_asr_if.serial_out_pos), .serial_out_neg(u_asr_if.serial_out_neg),
        .lvds_sel(u_asr_if.lvds_sel));
    always #25 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // ----
    // Bus cycles and sequences
    // ----
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge mclk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        check(q, exp);
    endtask
    // Waits for not busy and ready, since a command sent while busy, or a convert sent before ready, is dropped.
    task automatic wait_ready();
        do wb(1'b0, 8'h08, 32'h0); while (q[1:0] !== 2'b10);
    endtask
    task automatic do_cmd(input logic [2:0] c);
        wb(1'b1, 8'h00, {29'h0, c});
        wait_ready();
    endtask
    task automatic conv(input logic [15:0] code);
        analog_code <= code;
        do_cmd(3'h1);
    endtask
    task automatic pwr_cmd(input logic [2:0] c, input asr_pkg::asr_pwr_e p);
        do_cmd(c);
        check({29'h0, power_state}, {29'h0, p});
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        rd_chk(8'h08, 32'h0);
        wb(1'b1, 8'h10, 32'hFF);
        rd_chk(8'h10, 32'h0);
        rd_chk(8'h04, 32'h0);
        wait_ready();
        conv(16'hA5C3);
        check({16'h0, last_result}, 32'hA5C3);
        rd_chk(8'h08, 32'h2);
        conv(16'h3C5A);
        rd_chk(8'h08, 32'h6);
        rd_chk(8'h0C, 32'hA5C3);
        pwr_cmd(3'h2, asr_pkg::ASR_PWR_NAP);
        pwr_cmd(3'h4, asr_pkg::ASR_PWR_OPER);
        pwr_cmd(3'h3, asr_pkg::ASR_PWR_SLEEP);
        pwr_cmd(3'h5, asr_pkg::ASR_PWR_OPER);
        pwr_cmd(3'h3, asr_pkg::ASR_PWR_SLEEP);
        pwr_cmd(3'h4, asr_pkg::ASR_PWR_OPER);
        supply_good <= 1'b0;
        repeat (6) @(posedge mclk);
        check({31'h0, por_active}, 32'h1);
        supply_good <= 1'b1;
        repeat (6) @(posedge mclk);
        check({31'h0, por_active}, 32'h0);
        wb(1'b1, 8'h04, 32'h1);
        rd_chk(8'h04, 32'h1);
        conv(16'h8001);
        rd_chk(8'h08, 32'h2);
        conv(16'h7FFE);
        rd_chk(8'h0C, 32'h8001);
        pwr_cmd(3'h3, asr_pkg::ASR_PWR_SLEEP);
        pwr_cmd(3'h5, asr_pkg::ASR_PWR_OPER);
        finish_test();
    end
endmodule
